/* File: common/logic_ops_defines.svh */
`ifndef LOGIC_OPS_DEFINES_SVH
`define LOGIC_OPS_DEFINES_SVH

// ----------------------------------------------------------------------
// Constants
// ----------------------------------------------------------------------
`define BANK_SEL_LO 3
`define BANK_SEL_HI 4
`define CARRY_BIT 7
`define ACC_RESET 8'h00
`define LEN_ONE 2'h1
`define LEN_TWO 2'h2
`define LEN_THREE 2'h3
`define CYC_ONE 2'h1
`define CYC_TWO 2'h2
`endif

/* File: common/logic_ops_pkg.sv */
package logic_ops_pkg;
  typedef enum logic [3:0] {
    logic_and_op = 4'h0,
    logic_or_op = 4'h1,
    logic_xor_op = 4'h2,
    clear_acc_op = 4'h3,
    invert_acc_op = 4'h4,
    rotate_left_op = 4'h5,
    rotate_right_op = 4'h6,
    rotate_left_carry_op = 4'h7
  } op_t;
  typedef enum logic [2:0] {
    src_bank = 3'h0,
    src_direct = 3'h1,
    src_indirect = 3'h2,
    src_immediate = 3'h3,
    src_acc_to_direct = 3'h4,
    src_imm_to_direct = 3'h5,
    src_none = 3'h6
  } form_t;
  typedef struct packed {
    op_t op;
    form_t form;
    logic [2:0] reg_idx;
    logic [7:0] direct_addr;
    logic [7:0] imm;
  } instr_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mem_req_t;
endpackage : logic_ops_pkg

/* File: core/logic_ops_alu.sv */
`timescale 1ns/1ps
`include "logic_ops_defines.svh"
module logic_ops_alu (
  input logic_ops_pkg::op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic carry_in,
  output logic [7:0] result,
  output logic carry_out
);
  import logic_ops_pkg::*;
  // Pure combinational result; carry moves only for the nine-bit rotate.
  always_comb begin
    result = a;
    carry_out = carry_in;
    unique case (op)
      logic_and_op: result = a & b;
      logic_or_op: result = a | b;
      logic_xor_op: result = a ^ b;
      clear_acc_op: result = `ACC_RESET;
      invert_acc_op: result = ~a;
      rotate_left_op: result = {a[6:0], a[7]};
      rotate_right_op: result = {a[0], a[7:1]};
      rotate_left_carry_op: begin
        result = {a[6:0], carry_in};
        carry_out = a[7];
      end
    endcase
  end
endmodule : logic_ops_alu

/* File: core/byte_logic_ops_unit.sv */
`timescale 1ns/1ps
`include "logic_ops_defines.svh"
module byte_logic_ops_unit (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic start,
  input logic_ops_pkg::instr_t instr,
  input wire logic [7:0] psw_in,
  input wire logic [7:0] mem_rdata,
  output logic_ops_pkg::mem_req_t mem,
  output logic busy,
  output logic done,
  output logic [1:0] instr_len,
  output logic [1:0] cycles_used,
  output logic [7:0] acc,
  output logic carry
);
  import logic_ops_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_second = 2'b01
  } state_t;

  state_t state;
  instr_t held;
  logic [7:0] bank_addr;
  logic [7:0] operand;
  logic [7:0] alu_a;
  logic [7:0] alu_y;
  logic alu_c;
  logic to_direct;
  logic two_cycle;
  instr_t cur;

  // Register address in the active bank; reused for pointers.
  function automatic logic [7:0] bank_reg_addr(input logic [7:0] processor_status_word,
                                               input logic [2:0] idx);
    bank_reg_addr = {3'b000, processor_status_word[`BANK_SEL_HI:`BANK_SEL_LO], idx};
  endfunction : bank_reg_addr

  // The memory returns data in the same cycle it is addressed, so the
  // operand for every form is available within the issuing cycle.
  assign cur = (state == st_second) ? held : instr;
  assign to_direct = (cur.form == src_acc_to_direct) ||
                     (cur.form == src_imm_to_direct);
  assign two_cycle = (instr.form == src_imm_to_direct);
  assign bank_addr = bank_reg_addr(psw_in, cur.reg_idx);

  // Operand choice; the indirect path reads the pointer register and
  // uses its contents as operand, all in the single issuing cycle.
  always_comb begin
    operand = mem_rdata;
    unique case (cur.form)
      src_immediate: operand = cur.imm;
      src_acc_to_direct: operand = acc;
      src_imm_to_direct: operand = cur.imm;
      default: operand = mem_rdata;
    endcase
  end

  assign alu_a = to_direct ? mem_rdata : acc;

  logic_ops_alu u_alu (
    .op(cur.op),
    .a(alu_a),
    .b(operand),
    .carry_in(carry),
    .result(alu_y),
    .carry_out(alu_c)
  );

  // Memory request: bank register, pointer, or direct address.
  always_comb begin
    mem = '0;
    if (start && state == st_idle) begin
      mem.req = (cur.form != src_immediate) && (cur.form != src_none);
      unique case (cur.form)
        src_bank: mem.addr = bank_addr;
        src_indirect: mem.addr = bank_reg_addr(psw_in,
                                 {2'b00, cur.reg_idx[0]});
        src_direct, src_acc_to_direct: mem.addr = cur.direct_addr;
        src_imm_to_direct: mem.addr = cur.direct_addr;
        default: mem.addr = 8'h00;
      endcase
      mem.we = (cur.form == src_acc_to_direct);
      mem.wdata = alu_y;
    end else if (state == st_second) begin
      mem.req = 1'b1;
      mem.we = 1'b1;
      mem.addr = held.direct_addr;
      mem.wdata = alu_y;
    end
  end

  assign busy = (state == st_second);

  // Sequencer: one-cycle forms finish at once, immediate-to-direct forms
  // take a read cycle and a write cycle. Indirect forms use the contents
  // of the pointer register as operand, with no second RAM access.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= st_idle;
      held <= '0;
    end else if (ce) begin
      if (state == st_idle && start && two_cycle) begin
        state <= st_second;
        held <= instr;
      end else begin
        state <= st_idle;
      end
    end
  end

  // Accumulator and carry update.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc <= `ACC_RESET;
      carry <= 1'b0;
    end else if (ce && start && state == st_idle && !to_direct) begin
      acc <= alu_y;
      carry <= alu_c;
    end
  end

  // Completion report with instruction length and cycle count.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      done <= 1'b0;
      instr_len <= 2'h0;
      cycles_used <= 2'h0;
    end else if (ce) begin
      done <= (start && state == st_idle && !two_cycle) ||
              (state == st_second);
      if (state == st_second) begin
        instr_len <= `LEN_THREE;
        cycles_used <= `CYC_TWO;
      end else if (start && !two_cycle) begin
        cycles_used <= `CYC_ONE;
        unique case (instr.form)
          src_bank, src_indirect, src_none: instr_len <= `LEN_ONE;
          default: instr_len <= `LEN_TWO;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_two_cycle;
    @(posedge clk) disable iff (!nrst)
      (ce && start && !busy && instr.form == src_imm_to_direct) |=>
      busy && !done ##1 (!ce || (done && cycles_used == `CYC_TWO));
  endproperty
  a_two_cycle: assert property (p_two_cycle)
    else $error("two-cycle form timing wrong");

  property p_one_cycle;
    @(posedge clk) disable iff (!nrst)
      (ce && start && !busy && instr.form != src_imm_to_direct) |=>
      done && cycles_used == `CYC_ONE;
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("one-cycle form timing wrong");

  property p_clear;
    @(posedge clk) disable iff (!nrst)
      (ce && start && !busy && instr.op == clear_acc_op) |=>
      acc == `ACC_RESET;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not zero accumulator");

  property p_invert;
    @(posedge clk) disable iff (!nrst)
      (ce && start && !busy && instr.op == invert_acc_op) |=>
      acc == ~$past(acc);
  endproperty
  a_invert: assert property (p_invert)
    else $error("invert wrong");

  property p_rotl;
    @(posedge clk) disable iff (!nrst)
      (ce && start && !busy && instr.op == rotate_left_op) |=>
      acc == {$past(acc[6:0]), $past(acc[7])} && carry == $past(carry);
  endproperty
  a_rotl: assert property (p_rotl)
    else $error("rotate left wrong");

  property p_rlc;
    @(posedge clk) disable iff (!nrst)
      (ce && start && !busy && instr.op == rotate_left_carry_op) |=>
      carry == $past(acc[7]) && acc[0] == $past(carry);
  endproperty
  a_rlc: assert property (p_rlc)
    else $error("rotate through carry wrong");

  property p_bank;
    @(posedge clk) disable iff (!nrst)
      (start && !busy && instr.form == src_bank) |->
      mem.addr[4:3] == psw_in[4:3] && mem.addr[2:0] == instr.reg_idx;
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank register address wrong");

  property p_ptr;
    @(posedge clk) disable iff (!nrst)
      (start && !busy && instr.form == src_indirect) |->
      mem.addr[2:1] == 2'b00 && mem.req;
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("pointer register not zero or one");

  property p_writeback;
    @(posedge clk) disable iff (!nrst)
      (start && !busy && instr.form == src_acc_to_direct) |->
      mem.we && mem.addr == instr.direct_addr;
  endproperty
  a_writeback: assert property (p_writeback)
    else $error("direct write-back missing");
endmodule : byte_logic_ops_unit

/* File: dv/byte_logic_ops_unit_test.sv */
`timescale 1ns/1ps
module byte_logic_ops_unit_test;
  import logic_ops_pkg::*;
  // --------------------
  // Stimulus, memory and reference state
  // --------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic start = 1'b0;
  instr_t instr = '0;
  logic [7:0] psw_in = 8'h00;
  logic [7:0] mem_rdata;
  mem_req_t mem;
  logic busy, done, carry;
  logic [1:0] instr_len, cycles_used;
  logic [7:0] acc, m_acc;
  logic m_c = 1'b0;
  logic [7:0] ram [256];
  logic [7:0] mdl [256];
  logic [15:0] seed = 16'he5e6;
  typedef struct packed {
    logic [1:0] len; logic [1:0] cyc; logic [7:0] acc; logic c;
    logic [7:0] addr; logic [7:0] byt;
  } note_t;
  note_t q[$];
  note_t got;
  instr_t ri;
  int error_cnt = 0;
  int n_tests = 0;

  always #4 clk = ~clk;

  // Read data is combinational, as the unit expects it in the same cycle.
  assign mem_rdata = ram[mem.addr];
  // The RAM shares the core's enable, so a frozen request writes nothing.
  always @(posedge clk) begin
    if (ce && mem.req && mem.we) ram[mem.addr] <= mem.wdata;
  end

  byte_logic_ops_unit dut (.clk(clk), .nrst(nrst), .ce(ce), .start(start),
    .instr(instr), .psw_in(psw_in), .mem_rdata(mem_rdata), .mem(mem),
    .busy(busy), .done(done), .instr_len(instr_len),
    .cycles_used(cycles_used), .acc(acc), .carry(carry));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  // --------------------
  // Driver: note the expected result, then present the instruction
  // --------------------
  task automatic issue(input instr_t i);
    logic [7:0] a, b, r;
    note_t n;
    psw_in = {m_c, seed[6:0]};
    a = m_acc;
    b = i.imm;
    case (i.form)
      src_bank: b = mdl[{3'h0, psw_in[4:3], i.reg_idx}];
      src_direct: b = mdl[i.direct_addr];
      src_indirect: b = mdl[{3'h0, psw_in[4:3], 2'h0, i.reg_idx[0]}];
      src_acc_to_direct: begin a = mdl[i.direct_addr]; b = m_acc; end
      src_imm_to_direct: a = mdl[i.direct_addr];
      default: ;
    endcase
    case (i.op)
      logic_and_op: r = a & b;
      logic_or_op: r = a | b;
      logic_xor_op: r = a ^ b;
      clear_acc_op: r = 8'h00;
      invert_acc_op: r = ~a;
      rotate_left_op: r = {a[6:0], a[7]};
      rotate_right_op: r = {a[0], a[7:1]};
      default: begin r = {a[6:0], m_c}; m_c = a[7]; end
    endcase
    if (i.form inside {src_acc_to_direct, src_imm_to_direct})
      mdl[i.direct_addr] = r;
    else m_acc = r;
    n.len = (i.form == src_imm_to_direct) ? 2'h3 :
      (i.form inside {src_bank, src_indirect, src_none}) ? 2'h1 : 2'h2;
    n.cyc = (i.form == src_imm_to_direct) ? 2'h2 : 2'h1;
    n.acc = m_acc;
    n.c = m_c;
    n.addr = i.direct_addr;
    n.byt = mdl[i.direct_addr];
    q.push_back(n);
    instr = i;
    start = 1'b1;
    @(negedge clk);
    if (i.form == src_imm_to_direct) begin
      check({7'h0, busy}, 8'h01);
      // A clear offered while busy must be ignored, leaving acc alone.
      instr.op = clear_acc_op;
      instr.form = src_none;
      @(negedge clk);
    end
  endtask : issue

  // --------------------
  // Monitor: each done takes the oldest note and compares
  // --------------------
  always @(negedge clk) begin
    if (nrst && done !== 1'b0) begin
      if (q.size() == 0) check(8'h01, 8'h00);
      else begin
        got = q.pop_front();
        check({6'h0, instr_len}, {6'h0, got.len});
        check({6'h0, cycles_used}, {6'h0, got.cyc});
        check(acc, got.acc);
        check({7'h0, carry}, {7'h0, got.c});
        check(ram[got.addr], got.byt);
      end
    end
  end

  // A hang is cut short well beyond the length of the run.
  initial begin
    repeat (5000) @(posedge clk);
    check(8'h01, 8'h00);
    stop_test();
  end

  // --------------------
  // Main sequence: reset, then random instructions with freezes
  // --------------------
  initial begin
    m_acc = 8'h00;
    for (int k = 0; k < 256; k++) begin
      ram[k] = 8'(k * 37 + 5);
      mdl[k] = ram[k];
    end
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    check(acc, 8'h00);
    check({6'h0, busy, done}, 8'h00);
    check({7'h0, carry}, 8'h00);
    for (int t = 0; t < 400; t++) begin
      seed = lfsr(lfsr(seed));
      ri.op = op_t'(seed[2:0]);
      ri.form = (seed[2:0] < 3'h3) ? form_t'(seed[5:3] % 3'h6) : src_none;
      ri.reg_idx = seed[8:6];
      ri.direct_addr = seed[15:8];
      ri.imm = seed[10:3] ^ 8'h5a;
      // Freezing with ce low is tried only when nothing is in flight.
      if (t % 16 == 15) begin
        start = 1'b0;
        @(negedge clk);
        ce = 1'b0;
        start = 1'b1;
        repeat (2) @(negedge clk);
        ce = 1'b1;
      end
      issue(ri);
    end
    start = 1'b0;
    repeat (3) @(negedge clk);
    check(8'(q.size()), 8'h00);
    stop_test();
  end
endmodule : byte_logic_ops_unit_test
